/* hdl/logic_combiner_pkg.sv */
package logic_combiner_pkg;

   // ---------------------------------------------------------------
   // register word indexes (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  IDX_UNIT_CFG0   = 8'h00;  // six words, 0x00..0x05
   localparam logic [7:0]  IDX_OUT_SEL0    = 8'h06;  // terminals 0..4, then alarm relay
   localparam logic [7:0]  IDX_PROTO       = 8'h0C;
   localparam logic [7:0]  IDX_RX_LIMIT    = 8'h0D;
   localparam logic [7:0]  IDX_FAN_CTRL    = 8'h0E;
   localparam logic [7:0]  IDX_FAN_FULL    = 8'h0F;
   localparam logic [7:0]  IDX_CAP_LIMIT   = 8'h10;
   localparam logic [7:0]  IDX_LIFE_MON    = 8'h11;
   localparam logic [7:0]  IDX_INT_STATUS  = 8'h12;
   localparam logic [7:0]  IDX_INT_MASK    = 8'h13;
   localparam logic [7:0]  IDX_RESULTS     = 8'h14;

   // ---------------------------------------------------------------
   // field layout of a unit word
   // ---------------------------------------------------------------
   localparam int          UNIT_A_LSB      = 0;
   localparam int          UNIT_B_LSB      = 8;
   localparam int          UNIT_OP_LSB     = 16;

   // ---------------------------------------------------------------
   // codes
   // ---------------------------------------------------------------
   localparam int          NUM_UNITS       = 6;
   localparam int          NUM_TERMS       = 5;
   localparam logic [5:0]  CODE_RUN        = 6'h00;
   localparam logic [5:0]  CODE_FREQ_OVR   = 6'h02;
   localparam logic [5:0]  CODE_LINK_DISC  = 6'h20;  // 32
   localparam logic [5:0]  CODE_RESULT_LO  = 6'h21;  // 33
   localparam logic [5:0]  CODE_RESULT_HI  = 6'h26;  // 38
   localparam logic [5:0]  CODE_CAP_LIFE   = 6'h27;  // 39
   localparam logic [5:0]  CODE_FAN_DROP   = 6'h28;  // 40
   localparam logic [5:0]  CODE_MAX        = 6'h38;  // 56
   localparam logic [1:0]  OP_AND          = 2'h0;
   localparam logic [1:0]  OP_OR           = 2'h1;
   localparam logic [1:0]  OP_XOR          = 2'h2;
   localparam logic [1:0]  FAN_CTRL_NOWARN = 2'h1;
   localparam logic        PROTO_MODBUS    = 1'h1;

   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic [15:0] FAN_FULL_RST    = 16'hFFFF;
   localparam logic [31:0] CAP_LIMIT_RST   = 32'h0000_0000;
   localparam logic [13:0] RX_LIMIT_RST    = 14'h0000;
   localparam logic [13:0] RX_LIMIT_MAX    = 14'h270F;  // 99.99 s in 10 ms steps
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          TICK_MS         = 10;
   localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

endpackage

/* hdl/output_signal_logic_combiner.sv */
// Function
// - six units, each two operands and operator
// - operand code picks status signal 00..56
// - logic results never feed any operand
// - operator 00 AND, 01 OR, 02 XOR
// - codes 33..38 route unit results out
// - code 00 run, code 02 frequency overreached
// - disconnect flag only under Modbus-RTU protocol
// - timeout sets flag until next reception
// - timeout limit 0.00 to 99.99 seconds
// - code 32 routes disconnect flag out
// - code 39 routes capacitor life warning
// - fan flag at or below 75 percent
// - fan control 01 suppresses fan flag
//
// Implementation choices: the address-and-strobe port and the register offsets.
module output_signal_logic_combiner #(
   parameter int TICK_CYCLES = logic_combiner_pkg::TICK_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic [56:0] status_i,
   input  wire logic        rx_frame_done_i,
   input  wire logic [15:0] fan_speed_i,
   input  wire logic [7:0]  cap_temp_i,
   output logic      [4:0]  terminal_o,
   output logic             alarm_relay_o,
   output logic      [5:0]  logic_result_o,
   output logic             irq_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [5:0][5:0] opa;
      logic [5:0][5:0] opb;
      logic [5:0][1:0] op;
      logic [5:0][5:0] out_sel;
      logic            proto;
      logic [13:0]     rx_limit;
      logic [1:0]      fan_ctrl;
      logic [15:0]     fan_full;
      logic [31:0]     cap_limit;
      logic [31:0]     cap_acc;
      logic [2:0]      int_status;
      logic [2:0]      int_mask;
      logic [17:0]     div;
      logic [13:0]     tmo;
      logic            link;
      logic            cap;
      logic            fan;
      logic [5:0]      res;
      logic [4:0]      term;
      logic            alarm;
      logic            irq;
      logic [31:0]     rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic [63:0] oper_vec;
   logic [63:0] out_vec;
   logic [5:0]  unit_res;
   logic [5:0]  opa_val;
   logic [5:0]  opb_val;

   // ---------------------------------------------------------------
   // signal vectors
   // ---------------------------------------------------------------
   // results sit at 33..38 only in the output vector, so no unit can loop
   always_comb begin
      oper_vec                                 = {7'h00, status_i};
      oper_vec[logic_combiner_pkg::CODE_LINK_DISC] = s_r.link;
      oper_vec[logic_combiner_pkg::CODE_CAP_LIFE]  = s_r.cap;
      oper_vec[logic_combiner_pkg::CODE_FAN_DROP]  = s_r.fan;
      for (int k = 33; k <= 38; k++) begin
         oper_vec[k] = 1'b0;
      end
      out_vec = oper_vec;
      for (int k = 0; k < logic_combiner_pkg::NUM_UNITS; k++) begin
         out_vec[33 + k] = s_r.res[k];
      end
   end

   // ---------------------------------------------------------------
   // combining units
   // ---------------------------------------------------------------
   genvar u;
   generate
      for (u = 0; u < logic_combiner_pkg::NUM_UNITS; u++) begin : g_unit
         // codes above 56 read the zero-filled top of the vector
         assign opa_val[u] = oper_vec[s_r.opa[u]];
         assign opb_val[u] = oper_vec[s_r.opb[u]];
         always_comb begin
            unique case (s_r.op[u])
               logic_combiner_pkg::OP_AND: unit_res[u] = opa_val[u] & opb_val[u];
               logic_combiner_pkg::OP_OR:  unit_res[u] = opa_val[u] | opb_val[u];
               logic_combiner_pkg::OP_XOR: unit_res[u] = opa_val[u] ^ opb_val[u];
               default:                    unit_res[u] = 1'b0;
            endcase
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic        tick;
   logic        modbus;
   logic [17:0] fan_lhs;
   logic [17:0] fan_rhs;
   logic [2:0]  events;
   logic [5:0]  widx;

   always_comb begin
      s_nxt   = s_r;
      tick    = (s_r.div == 18'(TICK_CYCLES - 1));
      modbus  = (s_r.proto == logic_combiner_pkg::PROTO_MODBUS);
      fan_lhs = {fan_speed_i, 2'b00};
      fan_rhs = 18'({2'b00, s_r.fan_full} + {1'b0, s_r.fan_full, 1'b0});
      widx    = 6'(reg_addr_i - logic_combiner_pkg::IDX_OUT_SEL0);

      // 10 ms time base
      s_nxt.div = tick ? 18'h00000 : 18'(s_r.div + 18'h00001);

      // reception timeout; a limit of zero disables it
      if (!modbus || rx_frame_done_i) begin
         s_nxt.tmo  = 14'h0000;
         s_nxt.link = 1'b0;
      end else if (tick && !s_r.link && s_r.rx_limit != 14'h0000) begin
         s_nxt.tmo = 14'(s_r.tmo + 14'h0001);
         if (14'(s_r.tmo + 14'h0001) >= s_r.rx_limit) begin
            s_nxt.link = 1'b1;
         end
      end

      // capacitor wear: hotter boards age faster
      if (tick && s_r.cap_acc != 32'hFFFF_FFFF) begin
         s_nxt.cap_acc = 32'(s_r.cap_acc + {29'h0, cap_temp_i[7:6]} + 32'h1);
      end
      s_nxt.cap = (s_r.cap_limit != 32'h0) && (s_r.cap_acc >= s_r.cap_limit);

      s_nxt.fan = (s_r.fan_ctrl != logic_combiner_pkg::FAN_CTRL_NOWARN)
                  && (fan_lhs <= fan_rhs);

      s_nxt.res = unit_res;
      for (int t = 0; t < logic_combiner_pkg::NUM_TERMS; t++) begin
         s_nxt.term[t] = out_vec[s_r.out_sel[t]];
      end
      s_nxt.alarm = out_vec[s_r.out_sel[5]];

      // rising edges of the three flags; set beats a same-cycle clear
      events = {s_nxt.fan & ~s_r.fan, s_nxt.cap & ~s_r.cap, s_nxt.link & ~s_r.link};
      if (reg_wr_i && reg_addr_i == logic_combiner_pkg::IDX_INT_STATUS) begin
         s_nxt.int_status = s_r.int_status & ~reg_wdata_i[2:0];
      end
      s_nxt.int_status = s_nxt.int_status | events;
      s_nxt.irq        = |(s_r.int_status & s_r.int_mask);

      if (reg_wr_i) begin
         if (reg_addr_i < logic_combiner_pkg::IDX_OUT_SEL0) begin
            s_nxt.opa[reg_addr_i[2:0]] = reg_wdata_i[logic_combiner_pkg::UNIT_A_LSB +: 6];
            s_nxt.opb[reg_addr_i[2:0]] = reg_wdata_i[logic_combiner_pkg::UNIT_B_LSB +: 6];
            s_nxt.op[reg_addr_i[2:0]]  = reg_wdata_i[logic_combiner_pkg::UNIT_OP_LSB +: 2];
         end else if (reg_addr_i < logic_combiner_pkg::IDX_PROTO) begin
            s_nxt.out_sel[widx[2:0]] = reg_wdata_i[5:0];
         end else begin
            unique case (reg_addr_i)
               logic_combiner_pkg::IDX_PROTO:     s_nxt.proto = reg_wdata_i[0];
               logic_combiner_pkg::IDX_RX_LIMIT: begin
                  // clamp to 99.99 s
                  s_nxt.rx_limit = (reg_wdata_i[13:0] > logic_combiner_pkg::RX_LIMIT_MAX)
                                   ? logic_combiner_pkg::RX_LIMIT_MAX : reg_wdata_i[13:0];
               end
               logic_combiner_pkg::IDX_FAN_CTRL:  s_nxt.fan_ctrl  = reg_wdata_i[1:0];
               logic_combiner_pkg::IDX_FAN_FULL:  s_nxt.fan_full  = reg_wdata_i[15:0];
               logic_combiner_pkg::IDX_CAP_LIMIT: s_nxt.cap_limit = reg_wdata_i;
               logic_combiner_pkg::IDX_INT_MASK:  s_nxt.int_mask  = reg_wdata_i[2:0];
               default: ;
            endcase
         end
      end

      s_nxt.rdata = 32'h0000_0000;
      if (reg_rd_i) begin
         if (reg_addr_i < logic_combiner_pkg::IDX_OUT_SEL0) begin
            s_nxt.rdata = {14'h0, s_r.op[reg_addr_i[2:0]], 2'h0, s_r.opb[reg_addr_i[2:0]],
                           2'h0, s_r.opa[reg_addr_i[2:0]]};
         end else if (reg_addr_i < logic_combiner_pkg::IDX_PROTO) begin
            s_nxt.rdata = {26'h0, s_r.out_sel[widx[2:0]]};
         end else begin
            unique case (reg_addr_i)
               logic_combiner_pkg::IDX_PROTO:      s_nxt.rdata = {31'h0, s_r.proto};
               logic_combiner_pkg::IDX_RX_LIMIT:   s_nxt.rdata = {18'h0, s_r.rx_limit};
               logic_combiner_pkg::IDX_FAN_CTRL:   s_nxt.rdata = {30'h0, s_r.fan_ctrl};
               logic_combiner_pkg::IDX_FAN_FULL:   s_nxt.rdata = {16'h0, s_r.fan_full};
               logic_combiner_pkg::IDX_CAP_LIMIT:  s_nxt.rdata = s_r.cap_limit;
               logic_combiner_pkg::IDX_LIFE_MON:   s_nxt.rdata = {30'h0, s_r.fan, s_r.cap};
               logic_combiner_pkg::IDX_INT_STATUS: s_nxt.rdata = {29'h0, s_r.int_status};
               logic_combiner_pkg::IDX_INT_MASK:   s_nxt.rdata = {29'h0, s_r.int_mask};
               logic_combiner_pkg::IDX_RESULTS:    s_nxt.rdata = {26'h0, s_r.res};
               default:                            s_nxt.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_r           <= '0;
         s_r.rx_limit  <= logic_combiner_pkg::RX_LIMIT_RST;
         s_r.fan_full  <= logic_combiner_pkg::FAN_FULL_RST;
         s_r.cap_limit <= logic_combiner_pkg::CAP_LIMIT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_o    = s_r.rdata;
   assign terminal_o     = s_r.term;
   assign alarm_relay_o  = s_r.alarm;
   assign logic_result_o = s_r.res;
   assign irq_o          = s_r.irq;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_UNIT_AND: assert property (
      (s_r.op[0] == logic_combiner_pkg::OP_AND)
      |=> (s_r.res[0] == ($past(opa_val[0]) & $past(opb_val[0]))))
      else $error("unit 0 AND result wrong");
   AST_UNIT_OR: assert property (
      (s_r.op[1] == logic_combiner_pkg::OP_OR)
      |=> (s_r.res[1] == ($past(opa_val[1]) | $past(opb_val[1]))))
      else $error("unit 1 OR result wrong");
   AST_UNIT_XOR: assert property (
      (s_r.op[2] == logic_combiner_pkg::OP_XOR)
      |=> (s_r.res[2] == ($past(opa_val[2]) ^ $past(opb_val[2]))))
      else $error("unit 2 XOR result wrong");
   // a result code on operand A must act as a zero, so OR passes operand B alone
   AST_NO_RESULT_OPERAND: assert property (
      (s_r.opa[0] >= logic_combiner_pkg::CODE_RESULT_LO
       && s_r.opa[0] <= logic_combiner_pkg::CODE_RESULT_HI
       && s_r.op[0] == logic_combiner_pkg::OP_OR)
      |=> (s_r.res[0] == $past(opb_val[0])))
      else $error("result fed back into a unit");
   AST_LINK_PROTO: assert property (
      (s_r.proto != logic_combiner_pkg::PROTO_MODBUS) |=> !s_r.link)
      else $error("disconnect flag set outside Modbus-RTU");
   AST_LINK_HOLD: assert property (
      (s_r.link && !rx_frame_done_i && s_r.proto == logic_combiner_pkg::PROTO_MODBUS) |=> s_r.link)
      else $error("disconnect flag dropped without reception");
   AST_LINK_CLEAR: assert property (
      (s_r.link && rx_frame_done_i) |=> !s_r.link)
      else $error("disconnect flag survived a reception");
   AST_FAN_SUPPRESS: assert property (
      (s_r.fan_ctrl == logic_combiner_pkg::FAN_CTRL_NOWARN) |=> !s_r.fan)
      else $error("fan flag not suppressed");
   AST_FAN_SET: assert property (
      (s_r.fan_ctrl != logic_combiner_pkg::FAN_CTRL_NOWARN && fan_lhs <= fan_rhs) |=> s_r.fan)
      else $error("fan flag missing at low speed");
   AST_ROUTE_LINK: assert property (
      (s_r.out_sel[0] == logic_combiner_pkg::CODE_LINK_DISC) |=> (terminal_o[0] == $past(s_r.link)))
      else $error("terminal 0 not showing disconnect flag");
   AST_ROUTE_RESULT: assert property (
      (s_r.out_sel[5] == logic_combiner_pkg::CODE_RESULT_HI)
      |=> (alarm_relay_o == $past(s_r.res[5])))
      else $error("alarm relay not showing unit 5 result");
   AST_ROUTE_CAP: assert property (
      (s_r.out_sel[0] == logic_combiner_pkg::CODE_CAP_LIFE) |=> (terminal_o[0] == $past(s_r.cap)))
      else $error("terminal 0 not showing capacitor warning");
   AST_ROUTE_FAN: assert property (
      (s_r.out_sel[0] == logic_combiner_pkg::CODE_FAN_DROP) |=> (terminal_o[0] == $past(s_r.fan)))
      else $error("terminal 0 not showing fan flag");
   AST_RX_LIMIT_RANGE: assert property (
      s_r.rx_limit <= logic_combiner_pkg::RX_LIMIT_MAX)
      else $error("timeout limit beyond its top value");
   AST_LINK_TIMEOUT: assert property (
      (s_r.proto == logic_combiner_pkg::PROTO_MODBUS && !rx_frame_done_i && tick
       && s_r.rx_limit != 14'h0000 && 14'(s_r.tmo + 14'h0001) >= s_r.rx_limit)
      |=> s_r.link)
      else $error("disconnect flag missing after timeout");
   AST_CAP_OFF: assert property (
      (s_r.cap_limit == 32'h0000_0000) |=> !s_r.cap)
      else $error("capacitor warning with limit off");
   AST_RDATA_IDLE: assert property (
      !reg_rd_i |=> (reg_rdata_o == 32'h0000_0000))
      else $error("read data outside its read cycle");
   AST_IRQ: assert property (
      (|(s_r.int_status & s_r.int_mask)) |=> irq_o)
      else $error("interrupt not raised");
   AST_IRQ_LOW: assert property (
      !(|(s_r.int_status & s_r.int_mask)) |=> !irq_o)
      else $error("interrupt raised with nothing pending");

endmodule

/* testbench/output_load_model.sv */
module output_load_model (
   input  wire logic [4:0] terminal_i,
   input  wire logic       relay_i,
   output logic      [4:0] term_level_o,
   output logic            relay_level_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // resistive loads: level follows the drive, no hold of its own
   // ------------------------------
   assign term_level_o  = terminal_i;
   assign relay_level_o = relay_i;
endmodule

/* testbench/output_signal_logic_combiner_tb.sv */
module output_signal_logic_combiner_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, rx_frame_done_i, alarm_relay_o, irq_o;
   logic [7:0]  reg_addr_i, cap_temp_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   logic [56:0] status_i;
   logic [15:0] fan_speed_i;
   logic [4:0]  terminal_o, term_lvl;
   logic [5:0]  logic_result_o, res;
   logic        relay_lvl;
   int          n_mismatch = 0;
   int          n_tests = 0;
   // ------------------------------
   // design and load
   // ------------------------------
   output_signal_logic_combiner #(.TICK_CYCLES(4)) uut (
      .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .status_i(status_i), .rx_frame_done_i(rx_frame_done_i),
      .fan_speed_i(fan_speed_i), .cap_temp_i(cap_temp_i), .terminal_o(terminal_o),
      .alarm_relay_o(alarm_relay_o), .logic_result_o(logic_result_o), .irq_o(irq_o));
   output_load_model load (
      .terminal_i(terminal_o), .relay_i(alarm_relay_o),
      .term_level_o(term_lvl), .relay_level_o(relay_lvl));
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1 chk(nm, e, reg_rdata_o);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic setst(input logic [56:0] v);
      @(posedge clk_i);
      status_i <= v;
   endtask
   function automatic logic [31:0] cfg(logic [5:0] a, logic [5:0] b, logic [1:0] op);
      return {14'h0000, op, 2'h0, b, 2'h0, a};
   endfunction
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ------------------------------
   // clock, reset, watchdog
   // ------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      tally_and_finish;
   end
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      logic e;
      resetn_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; rx_frame_done_i = 1'b0;
      reg_addr_i = 8'h00; reg_wdata_i = 32'h0; status_i = '0;
      fan_speed_i = 16'hFFFF; cap_temp_i = 8'h00;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(logic_combiner_pkg::IDX_FAN_FULL, 32'h0000FFFF, "fan_full");
      rd(logic_combiner_pkg::IDX_UNIT_CFG0, 32'h0, "unit_cfg");
      rd(8'hFF, 32'h0, "unmapped");
      wr(8'hFF, 32'hFFFFFFFF);
      wr(logic_combiner_pkg::IDX_RX_LIMIT, 32'h0000FFFF);
      rd(logic_combiner_pkg::IDX_RX_LIMIT, 32'h0000270F, "rx_limit");
      // every unit, every operator, every operand pair; 56 is the top code
      for (int k = 0; k < 6; k++) begin
         for (int op = 0; op < 3; op++) begin
            wr(logic_combiner_pkg::IDX_UNIT_CFG0 + 8'(k), cfg(6'(4 + k), 6'h38, 2'(op)));
            for (int ab = 0; ab < 4; ab++) begin
               setst((57'(ab[0]) << (4 + k)) | (57'(ab[1]) << 56));
               e = (op == 0) ? (ab[0] & ab[1]) : (op == 1) ? (ab[0] | ab[1]) : (ab[0] ^ ab[1]);
               step(1);
               chk("unit_result", 32'(e), 32'(logic_result_o[k]));
            end
         end
      end
      // routing of all six results; unit 0 is run AND freq overreached
      wr(logic_combiner_pkg::IDX_UNIT_CFG0, cfg(6'h00, 6'h02, 2'h0));
      // units 1..5 are still XOR of bit 4+k with bit 56
      setst(57'h1 << 56 | 57'h2A5);
      res = 6'b010101;
      for (int j = 0; j < 6; j++) begin
         wr(logic_combiner_pkg::IDX_OUT_SEL0 + 8'(j), 32'(6'h21 + 6'(j)));
      end
      step(3);
      chk("results", 32'(res), 32'(logic_result_o));
      chk("terminals", 32'(res[4:0]), 32'(term_lvl));
      chk("relay", 32'(res[5]), 32'(relay_lvl));
      rd(logic_combiner_pkg::IDX_RESULTS, 32'(res), "results_reg");
      // result codes fed as operands must read as zero
      setst(57'h1 << 56 | 57'h154);
      wr(logic_combiner_pkg::IDX_UNIT_CFG0, cfg(6'h22, 6'h00, 2'h1));
      step(2);
      chk("result_operand", 32'h0, 32'(logic_result_o[0]));
      // link flag: off unless modbus, set on timeout, cleared by reception
      wr(logic_combiner_pkg::IDX_OUT_SEL0, 32'h20);
      wr(logic_combiner_pkg::IDX_RX_LIMIT, 32'h2);
      step(20);
      chk("link_no_modbus", 32'h0, 32'(term_lvl[0]));
      wr(logic_combiner_pkg::IDX_PROTO, 32'h1);
      step(20);
      chk("link_timeout", 32'h1, 32'(term_lvl[0]));
      chk("irq_masked", 32'h0, 32'(irq_o));
      rd(logic_combiner_pkg::IDX_INT_STATUS, 32'h1, "int_status");
      wr(logic_combiner_pkg::IDX_INT_MASK, 32'h1);
      step(2);
      chk("irq_on", 32'h1, 32'(irq_o));
      wr(logic_combiner_pkg::IDX_INT_STATUS, 32'h1);
      step(2);
      chk("irq_cleared", 32'h0, 32'(irq_o));
      @(posedge clk_i);
      rx_frame_done_i <= 1'b1;
      @(posedge clk_i);
      rx_frame_done_i <= 1'b0;
      step(2);
      chk("link_rx_clear", 32'h0, 32'(term_lvl[0]));
      wr(logic_combiner_pkg::IDX_PROTO, 32'h0);
      wr(logic_combiner_pkg::IDX_INT_STATUS, 32'h7);
      // capacitor wear; its status bit stays masked off
      wr(logic_combiner_pkg::IDX_OUT_SEL0, 32'h27);
      cap_temp_i <= 8'hC0;
      wr(logic_combiner_pkg::IDX_CAP_LIMIT, 32'h3);
      step(20);
      chk("cap_warn", 32'h1, 32'(term_lvl[0]));
      chk("irq_cap_masked", 32'h0, 32'(irq_o));
      // fan drop at exactly 75 percent, not above, suppressed by control 01
      wr(logic_combiner_pkg::IDX_OUT_SEL0, 32'h28);
      wr(logic_combiner_pkg::IDX_FAN_FULL, 32'h64);
      fan_speed_i <= 16'h004C;
      step(3);
      chk("fan_above", 32'h0, 32'(term_lvl[0]));
      @(posedge clk_i);
      fan_speed_i <= 16'h004B;
      step(3);
      chk("fan_at_75", 32'h1, 32'(term_lvl[0]));
      wr(logic_combiner_pkg::IDX_FAN_CTRL, 32'h1);
      step(3);
      chk("fan_suppressed", 32'h0, 32'(term_lvl[0]));
      tally_and_finish;
   end
endmodule
